// File: rtl/b1srm_map.svh
// Register map constants for the bank-one special register block
`ifndef B1SRM_MAP_SVH
`define B1SRM_MAP_SVH
`define B1SRM_ADDR_INDIRECT 8'h80
`define B1SRM_ADDR_OPTION 8'h81
`define B1SRM_ADDR_PCL 8'h82
`define B1SRM_ADDR_STATUS 8'h83
`define B1SRM_ADDR_POINTER 8'h84
`define B1SRM_ADDR_DIR_A 8'h85
`define B1SRM_ADDR_DIR_B 8'h86
`define B1SRM_ADDR_DIR_C 8'h87
`define B1SRM_ADDR_DIR_D 8'h88
`define B1SRM_ADDR_DIR_E 8'h89
`define B1SRM_ADDR_HOLD 8'h8a
`define B1SRM_ADDR_INTCTL 8'h8b
`define B1SRM_ADDR_PIE 8'h8c
`define B1SRM_ADDR_PWR 8'h8e
`define B1SRM_ADDR_PERIOD 8'h92
`define B1SRM_ADDR_SLAVE 8'h93
`define B1SRM_ADDR_SSTATE 8'h94
`define B1SRM_ADDR_RESET_CTL 8'hc0
`define B1SRM_ADDR_PC_STATE 8'hc4
`define B1SRM_ADDR_MIRROR_BASE 8'h00
`define B1SRM_BANK_BIT 7
`define B1SRM_EXT_BIT 6
`define B1SRM_RST_OPTION 8'hff
`define B1SRM_RST_DIR8 8'hff
`define B1SRM_RST_DIR6 6'h3f
`define B1SRM_RST_DIR_E 8'h07
`define B1SRM_RST_PERIOD 8'hff
`define B1SRM_RST_ZERO8 8'h00
`define B1SRM_RST_HOLD 5'h00
`define B1SRM_RST_STATUS_POR 8'h18
`define B1SRM_STATUS_KEEP_OTHER 8'h07
`define B1SRM_STATUS_FLAGS_OTHER 8'h00
`define B1SRM_INTCTL_KEEP 8'h01
`define B1SRM_PIE_MASK 8'hbf
`define B1SRM_SSTATE_MASK 8'h3f
`define B1SRM_DIR_E_MASK 8'hf7
`define B1SRM_DIR_E_RO_MASK 8'hf0
`define B1SRM_BANK_SEL_BIT 5
`define B1SRM_PWR_POR_FLAG 1
`define B1SRM_PWR_BOR_FLAG 0
`define B1SRM_RESET_CTL_POR 0
`define B1SRM_RESET_CTL_BOR 1
`define B1SRM_RESET_CTL_OTHER 2
`endif

// File: rtl/b1srm_pkg.sv
// Types shared by the bank-one special register block
package b1srm_pkg;
    typedef enum logic [1:0] {
        B1SRM_RST_NONE,
        B1SRM_RST_POWER,
        B1SRM_RST_BROWN,
        B1SRM_RST_OTHER
    } b1srm_reset_type;
    typedef struct packed {
        logic [7:0] addr;
        logic write;
        logic read;
        logic [7:0] wdata;
    } b1srm_access_type;
    typedef enum logic {
        B1SRM_ADDR_PH,
        B1SRM_DATA_PH
    } b1srm_phase_type;
endpackage : b1srm_pkg

// File: rtl/b1srm_ahb_if.sv
// AHB-Lite slave front end turning bus transfers into register accesses
`include "b1srm_map.svh"
module b1srm_ahb_if (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output b1srm_pkg::b1srm_access_type acc,
    output logic data_phase
);
    logic [7:0] addr_q;
    logic wr_q;
    logic act_q;
    wire take = hsel && hready && htrans[1];
    // Byte address divided by four gives the register index
    wire [7:0] index = haddr[9:2];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_q <= 8'h00;
            wr_q <= 1'b0;
            act_q <= 1'b0;
        end else if (hready) begin
            addr_q <= index;
            wr_q <= take && hwrite;
            act_q <= take;
        end
    end
    assign acc.addr = addr_q;
    assign acc.write = act_q && wr_q;
    assign acc.read = act_q && !wr_q;
    assign acc.wdata = hwdata[7:0];
    assign data_phase = act_q;
endmodule : b1srm_ahb_if

// File: rtl/b1srm_reset_ctl.sv
// Reset class tracker choosing power-up or other-reset values
`include "b1srm_map.svh"
module b1srm_reset_ctl (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [2:0] req,
    output b1srm_pkg::b1srm_reset_type rst_kind
);
    b1srm_pkg::b1srm_reset_type kind_q;
    // Power-on beats brown-out beats other resets
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            kind_q <= b1srm_pkg::B1SRM_RST_POWER;
        end else if (req[`B1SRM_RESET_CTL_POR]) begin
            kind_q <= b1srm_pkg::B1SRM_RST_POWER;
        end else if (req[`B1SRM_RESET_CTL_BOR]) begin
            kind_q <= b1srm_pkg::B1SRM_RST_BROWN;
        end else if (req[`B1SRM_RESET_CTL_OTHER]) begin
            kind_q <= b1srm_pkg::B1SRM_RST_OTHER;
        end else begin
            kind_q <= b1srm_pkg::B1SRM_RST_NONE;
        end
    end
    assign rst_kind = kind_q;
endmodule : b1srm_reset_ctl

// File: rtl/b1srm_top.sv
// Bank-one special register file behind an AHB-Lite slave
// How it works
// - Mirrored registers answer the same at bank zero and bank one.
// - Indirect pointer holds the address and survives all but power-up and brown-out.
// - Upper counter bits come only from holding register on counter load.
// - Master-clear and watchdog resets use the other-reset values.
// - Direction registers A to D reset to all ones on every reset; E resets to 07h.
// - Serial slave address resets to zero on every reset.
// - Unimplemented addresses and bits read zero and ignore writes.
//
// The AHB-Lite interface to the registers was decided locally.
`include "b1srm_map.svh"
module b1srm_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [7:0] port_a_direction,
    output logic [7:0] port_b_direction,
    output logic [7:0] port_c_direction,
    output logic [7:0] port_d_direction,
    output logic [7:0] option_config,
    output logic [7:0] timer_period,
    output logic [7:0] serial_slave_address,
    output logic [7:0] indirect_pointer,
    output logic [12:0] program_counter
);
    b1srm_pkg::b1srm_access_type acc;
    b1srm_pkg::b1srm_reset_type rst_kind;
    logic dphase;
    logic [7:0] opt_q, pcl_q, stat_q, ptr_q, dir_e_q, ictl_q, pie_q;
    logic [7:0] per_q, slv_q, sst_q, rctl_q;
    logic [5:0] dir_a_q;
    logic [7:0] dir_b_q, dir_c_q, dir_d_q;
    logic [4:0] hold_q, pch_q;
    logic [1:0] pwr_q;
    logic [31:0] rdata_q;

    b1srm_ahb_if u_if (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .hwdata(hwdata),
        .acc(acc),
        .data_phase(dphase)
    );

    b1srm_reset_ctl u_rst (
        .hclk(hclk),
        .hresetn(hresetn),
        .req(rctl_q[2:0]),
        .rst_kind(rst_kind)
    );

    // Folds a bank-zero mirror onto its bank-one address
    function automatic logic [7:0] fold(input logic [7:0] a);
        logic m;
        m = (a == `B1SRM_ADDR_INDIRECT) || (a == `B1SRM_ADDR_PCL) ||
            (a == `B1SRM_ADDR_STATUS) || (a == `B1SRM_ADDR_POINTER) ||
            (a == `B1SRM_ADDR_HOLD) || (a == `B1SRM_ADDR_INTCTL);
        fold = m ? a : 8'h00;
    endfunction : fold

    wire [7:0] up_addr = acc.addr | 8'h80;
    wire mirror_hit = (fold(up_addr) != 8'h00) &&
        (acc.addr[`B1SRM_BANK_BIT] == 1'b0);
    wire bank_one = stat_q[`B1SRM_BANK_SEL_BIT] ||
        acc.addr[`B1SRM_BANK_BIT];
    wire [7:0] ea = mirror_hit ? up_addr :
        (acc.addr == `B1SRM_ADDR_RESET_CTL) ? acc.addr :
        (acc.addr == `B1SRM_ADDR_PC_STATE) ? acc.addr :
        (bank_one && !acc.addr[`B1SRM_EXT_BIT]) ? up_addr : 8'h00;
    wire wr = acc.write;
    wire [7:0] wd = acc.wdata;
    wire any_rst = rst_kind != b1srm_pkg::B1SRM_RST_NONE;
    wire power_rst = (rst_kind == b1srm_pkg::B1SRM_RST_POWER) ||
        (rst_kind == b1srm_pkg::B1SRM_RST_BROWN);
    wire w_opt = wr && (ea == `B1SRM_ADDR_OPTION);
    wire w_pcl = wr && (ea == `B1SRM_ADDR_PCL);
    wire w_stat = wr && (ea == `B1SRM_ADDR_STATUS);
    wire w_ptr = wr && (ea == `B1SRM_ADDR_POINTER);
    wire w_da = wr && (ea == `B1SRM_ADDR_DIR_A);
    wire w_db = wr && (ea == `B1SRM_ADDR_DIR_B);
    wire w_dc = wr && (ea == `B1SRM_ADDR_DIR_C);
    wire w_dd = wr && (ea == `B1SRM_ADDR_DIR_D);
    wire w_de = wr && (ea == `B1SRM_ADDR_DIR_E);
    wire w_hold = wr && (ea == `B1SRM_ADDR_HOLD);
    wire w_ictl = wr && (ea == `B1SRM_ADDR_INTCTL);
    wire w_pie = wr && (ea == `B1SRM_ADDR_PIE);
    wire w_pwr = wr && (ea == `B1SRM_ADDR_PWR);
    wire w_per = wr && (ea == `B1SRM_ADDR_PERIOD);
    wire w_slv = wr && (ea == `B1SRM_ADDR_SLAVE);
    wire w_sst = wr && (ea == `B1SRM_ADDR_SSTATE);
    wire w_rctl = wr && (ea == `B1SRM_ADDR_RESET_CTL);

    logic [7:0] rd_mux;
    always_comb begin
        if (ea == `B1SRM_ADDR_INDIRECT) begin
            rd_mux = `B1SRM_RST_ZERO8;
        end else if (ea == `B1SRM_ADDR_OPTION) begin
            rd_mux = opt_q;
        end else if (ea == `B1SRM_ADDR_PCL) begin
            rd_mux = pcl_q;
        end else if (ea == `B1SRM_ADDR_STATUS) begin
            rd_mux = stat_q;
        end else if (ea == `B1SRM_ADDR_POINTER) begin
            rd_mux = ptr_q;
        end else if (ea == `B1SRM_ADDR_DIR_A) begin
            rd_mux = {2'b00, dir_a_q};
        end else if (ea == `B1SRM_ADDR_DIR_B) begin
            rd_mux = dir_b_q;
        end else if (ea == `B1SRM_ADDR_DIR_C) begin
            rd_mux = dir_c_q;
        end else if (ea == `B1SRM_ADDR_DIR_D) begin
            rd_mux = dir_d_q;
        end else if (ea == `B1SRM_ADDR_DIR_E) begin
            rd_mux = dir_e_q & `B1SRM_DIR_E_MASK;
        end else if (ea == `B1SRM_ADDR_HOLD) begin
            rd_mux = {3'b000, hold_q};
        end else if (ea == `B1SRM_ADDR_INTCTL) begin
            rd_mux = ictl_q;
        end else if (ea == `B1SRM_ADDR_PIE) begin
            rd_mux = pie_q;
        end else if (ea == `B1SRM_ADDR_PWR) begin
            rd_mux = {6'b00_0000, pwr_q};
        end else if (ea == `B1SRM_ADDR_PERIOD) begin
            rd_mux = per_q;
        end else if (ea == `B1SRM_ADDR_SLAVE) begin
            rd_mux = slv_q;
        end else if (ea == `B1SRM_ADDR_SSTATE) begin
            rd_mux = sst_q & `B1SRM_SSTATE_MASK;
        end else if (ea == `B1SRM_ADDR_PC_STATE) begin
            rd_mux = {3'b000, pch_q};
        end else begin
            rd_mux = `B1SRM_RST_ZERO8;
        end
    end

    // Read data caught in the wait cycle, held while the master takes it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (acc.read && !hreadyout) begin
            rdata_q <= {24'h00_0000, rd_mux};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dir_a_q <= `B1SRM_RST_DIR6;
            dir_b_q <= `B1SRM_RST_DIR8;
            dir_c_q <= `B1SRM_RST_DIR8;
            dir_d_q <= `B1SRM_RST_DIR8;
            dir_e_q <= `B1SRM_RST_DIR_E;
        end else if (any_rst) begin
            dir_a_q <= `B1SRM_RST_DIR6;
            dir_b_q <= `B1SRM_RST_DIR8;
            dir_c_q <= `B1SRM_RST_DIR8;
            dir_d_q <= `B1SRM_RST_DIR8;
            dir_e_q <= `B1SRM_RST_DIR_E;
        end else begin
            if (w_da) dir_a_q <= wd[5:0];
            if (w_db) dir_b_q <= wd;
            if (w_dc) dir_c_q <= wd;
            if (w_dd) dir_d_q <= wd;
            // Buffer status bits stay read-only
            if (w_de) dir_e_q <= (dir_e_q & `B1SRM_DIR_E_RO_MASK) |
                (wd & ~`B1SRM_DIR_E_RO_MASK & `B1SRM_DIR_E_MASK);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slv_q <= `B1SRM_RST_ZERO8;
            opt_q <= `B1SRM_RST_OPTION;
            per_q <= `B1SRM_RST_PERIOD;
            sst_q <= `B1SRM_RST_ZERO8;
            pie_q <= `B1SRM_RST_ZERO8;
        end else if (any_rst) begin
            slv_q <= `B1SRM_RST_ZERO8;
            opt_q <= `B1SRM_RST_OPTION;
            per_q <= `B1SRM_RST_PERIOD;
            sst_q <= `B1SRM_RST_ZERO8;
            pie_q <= `B1SRM_RST_ZERO8;
        end else begin
            if (w_slv) slv_q <= wd;
            if (w_opt) opt_q <= wd;
            if (w_per) per_q <= wd;
            if (w_sst) sst_q <= wd & `B1SRM_SSTATE_MASK;
            if (w_pie) pie_q <= wd & `B1SRM_PIE_MASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ptr_q <= `B1SRM_RST_ZERO8;
        end else if (power_rst) begin
            ptr_q <= `B1SRM_RST_ZERO8;
        end else if (w_ptr) begin
            ptr_q <= wd;
        end
    end

    // other-reset values for status and interrupt control
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_q <= `B1SRM_RST_STATUS_POR;
            ictl_q <= `B1SRM_RST_ZERO8;
            pwr_q <= 2'b00;
        end else if (power_rst) begin
            stat_q <= `B1SRM_RST_STATUS_POR;
            ictl_q <= `B1SRM_RST_ZERO8;
            pwr_q <= 2'b00;
        end else if (rst_kind == b1srm_pkg::B1SRM_RST_OTHER) begin
            stat_q <= (stat_q & `B1SRM_STATUS_KEEP_OTHER) |
                `B1SRM_STATUS_FLAGS_OTHER;
            ictl_q <= ictl_q & `B1SRM_INTCTL_KEEP;
        end else begin
            if (w_stat) stat_q <= wd;
            if (w_ictl) ictl_q <= wd;
            if (w_pwr) pwr_q <= wd[1:0];
        end
    end

    // upper bits loaded from holding register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_q <= `B1SRM_RST_HOLD;
            pcl_q <= `B1SRM_RST_ZERO8;
            pch_q <= `B1SRM_RST_HOLD;
        end else if (any_rst) begin
            hold_q <= `B1SRM_RST_HOLD;
            pcl_q <= `B1SRM_RST_ZERO8;
            pch_q <= `B1SRM_RST_HOLD;
        end else begin
            if (w_hold) hold_q <= wd[4:0];
            if (w_pcl) begin
                pcl_q <= wd;
                pch_q <= hold_q;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rctl_q <= `B1SRM_RST_ZERO8;
        end else if (w_rctl) begin
            rctl_q <= wd;
        end else begin
            rctl_q <= `B1SRM_RST_ZERO8;
        end
    end

    // one wait state on reads so hrdata leaves a flip-flop
    wire rd_take = hsel && hready && htrans[1] && !hwrite;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= !rd_take;
            hresp <= 1'b0;
        end
    end

    assign hrdata = rdata_q;
    assign port_a_direction = {2'b00, dir_a_q};
    assign port_b_direction = dir_b_q;
    assign port_c_direction = dir_c_q;
    assign port_d_direction = dir_d_q;
    assign option_config = opt_q;
    assign timer_period = per_q;
    assign serial_slave_address = slv_q;
    assign indirect_pointer = ptr_q;
    assign program_counter = {pch_q, pcl_q};
endmodule : b1srm_top

// File: sim/b1srm_top_asserts.sv
// Port-level checks for the bank-one register block
module b1srm_top_asserts (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [7:0] port_a_direction,
    input wire logic [7:0] port_b_direction,
    input wire logic [7:0] port_c_direction,
    input wire logic [7:0] serial_slave_address,
    input wire logic [7:0] indirect_pointer,
    input wire logic [12:0] program_counter
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    wire logic [7:0] idx = haddr[9:2];
    wire logic take = hsel && hready && htrans[1];
    // Address phase followed by its data phase
    sequence wr_at(hit);
        take && hwrite && hit ##1 1'b1;
    endsequence
    sequence rd_at(hit);
        take && !hwrite && hit ##1 1'b1;
    endsequence
    sequence soft_rst;
        take && hwrite && idx == 8'hc0 ##1 hwdata[2:0] != 3'b000;
    endsequence
    a_ready_high: assert property (take && hwrite |=> hreadyout)
        else $error("write data phase not ready");
    a_read_wait: assert property (
        take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_resp_okay: assert property (!hresp)
        else $error("hresp not okay");
    a_rdata_upper: assert property (hrdata[31:8] == '0)
        else $error("hrdata upper bits set");
    a_dira_upper: assert property (port_a_direction[7:6] == 2'b00)
        else $error("port a direction upper bits set");
    a_reset_dirs: assert property ($rose(hresetn) |->
        port_a_direction == 8'h3f && port_b_direction == 8'hff)
        else $error("direction reset value wrong");
    a_reset_slave: assert property ($rose(hresetn) |->
        serial_slave_address == 8'h00)
        else $error("slave address reset value wrong");
    a_ptr_mirror: assert property (
        wr_at(idx inside {8'h04, 8'h84}) |=>
        indirect_pointer == $past(hwdata[7:0]))
        else $error("pointer write lost");
    a_pcl_load: assert property (
        wr_at(idx inside {8'h02, 8'h82}) |=>
        program_counter[7:0] == $past(hwdata[7:0]))
        else $error("counter low byte not loaded");
    a_dirb_write: assert property (wr_at(idx == 8'h86) |=>
        port_b_direction == $past(hwdata[7:0]))
        else $error("direction write lost");
    a_unimpl_read: assert property (rd_at(idx inside
        {8'h8d, [8'h8f:8'h91], [8'h95:8'h9f]}) |=> hrdata == '0)
        else $error("unimplemented read not zero");
    a_soft_dirs: assert property (soft_rst |->
        ##[1:4] port_b_direction == 8'hff)
        else $error("soft reset left direction");
endmodule : b1srm_top_asserts

bind b1srm_top b1srm_top_asserts b1srm_top_asserts_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .port_a_direction(port_a_direction),
    .port_b_direction(port_b_direction),
    .port_c_direction(port_c_direction),
    .serial_slave_address(serial_slave_address),
    .indirect_pointer(indirect_pointer),
    .program_counter(program_counter));

// File: sim/tb_top.sv
// Self-checking bench for the bank-one register block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire logic hready;
    logic [7:0] pa, pb, pc, pd, opt, per, slv, ptr;
    logic [12:0] pcnt;
    int mismatches, tests_run;
    logic [7:0] ri [15] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85,
        8'h86, 8'h87, 8'h88, 8'h89, 8'h8a, 8'h8c, 8'h92, 8'h93, 8'h94};
    logic [7:0] re [15] = '{8'h00, 8'hff, 8'h00, 8'h18, 8'h00, 8'h3f,
        8'hff, 8'hff, 8'hff, 8'h07, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
    logic [7:0] ui [6] = '{8'h8d, 8'h8f, 8'h90, 8'h91, 8'h95, 8'h9f};
    logic [7:0] sc [3] = '{8'h04, 8'h02, 8'h01};
    logic [7:0] pe [3] = '{8'h5a, 8'h00, 8'h00};

    assign hready = hreadyout;

    b1srm_top b1srm_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .port_a_direction(pa),
        .port_b_direction(pb), .port_c_direction(pc),
        .port_d_direction(pd), .option_config(opt), .timer_period(per),
        .serial_slave_address(slv), .indirect_pointer(ptr),
        .program_counter(pcnt));

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    task automatic stop(string nm);
        mismatches++;
        $display("BAD %s expected response seen none", nm);
        close_out();
    endtask : stop

    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) stop("hready");
    endtask : wait_ready

    // Read data is taken at the edge that ends the data phase
    task automatic xfer(logic wr, logic [7:0] i, logic [7:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {22'h0, i, 2'b00};
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        wait_ready();
        rd = hrdata;
        @(posedge hclk);
    endtask : xfer

    task automatic wr(logic [7:0] i, logic [7:0] d);
        xfer(1'b1, i, d);
    endtask : wr

    task automatic rchk(logic [7:0] i, logic [7:0] e, string nm);
        xfer(1'b0, i, 8'h00);
        chk(nm, {8'h00, e}, rd[15:0]);
    endtask : rchk

    task automatic wait_dir();
        int n;
        n = 0;
        while (pb !== 8'hff && n < 10) begin
            @(negedge hclk);
            n++;
        end
        if (pb !== 8'hff) stop("soft reset");
    endtask : wait_dir

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = '0;
        htrans = 2'b00;
        hsize = 3'b010;
        hwdata = '0;
        mismatches = 0;
        tests_run = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("dir_a", 16'h003f, {8'h00, pa});
        chk("dir_d", 16'h00ff, {8'h00, pd});
        chk("dir_c", 16'h00ff, {8'h00, pc});
        chk("slave", 16'h0000, {8'h00, slv});
        chk("period", 16'h00ff, {8'h00, per});
        chk("option", 16'h00ff, {8'h00, opt});
        for (int k = 0; k < 15; k++) begin
            rchk(ri[k], re[k], "reset value");
        end
        $display("test reset values done");
        wr(8'h84, 8'h5a);
        rchk(8'h04, 8'h5a, "ptr_mirror");
        chk("ptr_port", 16'h005a, {8'h00, ptr});
        wr(8'h0a, 8'hff);
        rchk(8'h8a, 8'h1f, "hold_bits");
        wr(8'h82, 8'h34);
        chk("pc_load", 16'h1f34, {3'b000, pcnt});
        rchk(8'h02, 8'h34, "pcl_mirror");
        wr(8'h8b, 8'h38);
        rchk(8'h0b, 8'h38, "intctl_mirror");
        $display("test mirrors done");
        for (int k = 0; k < 6; k++) begin
            wr(ui[k], 8'hff);
            rchk(ui[k], 8'h00, "unimpl");
        end
        wr(8'h85, 8'hff);
        rchk(8'h85, 8'h3f, "dir_a_bits");
        wr(8'h8c, 8'hbf);
        rchk(8'h8c, 8'hbf, "pie_kept");
        wr(8'h8e, 8'h01);
        rchk(8'h8e, 8'h01, "pwr_kept");
        wr(8'h92, 8'h3c);
        chk("period_port", 16'h003c, {8'h00, per});
        $display("test unimplemented done");
        rchk(8'h05, 8'h00, "bank0_plain");
        wr(8'h83, 8'h20);
        rchk(8'h05, 8'h3f, "bank1_plain");
        wr(8'h83, 8'h00);
        $display("test bank steering done");
        for (int k = 0; k < 3; k++) begin
            wr(8'h84, 8'h5a);
            wr(8'h86, 8'h0f);
            wr(8'h93, 8'h42);
            wr(8'hc0, sc[k]);
            wait_dir();
            rchk(8'h84, pe[k], "ptr_after");
            rchk(8'h86, 8'hff, "dir_b_after");
            rchk(8'h93, 8'h00, "slave_after");
            rchk(8'h8a, 8'h00, "hold_after");
        end
        $display("test soft resets done");
        close_out();
    end
endmodule : tb_top
